/* logic/spk_regs.vh */
// Overview of operation
// - The speaker driver runs only while software holds the power bit D1 of page-one register 0x2D at one.
// - The output gain is the three-bit field D6 to D4 of page-one register 0x30.
// - A gain field of 000 mutes the speaker output instead of amplifying.
// - Short-circuit protection cannot be disabled and shuts the output stage down on overcurrent, never limiting current.
// - Read-only bit D7 of page-zero register 0x2E reports that overcurrent disabled the output.
// - After an overcurrent shutdown the stage stays off until a reset, and a master reset returns every register to default.
// - Writing one to the power bit is a power-stage reset that keeps other settings and shuts down again if the fault remains.
// - Thermal protection is always on, stops switching while hot and resumes by itself once cool.
// - Read-only bit D7 of page-zero register 0x2D reports overtemperature.
// - A mixer routes either or both playback channels to the speaker and can swap the two channels.
// - The general-purpose pin can be an input so software can watch an active-low external fault line.
// - A short while the power bit is set, or any overtemperature fault, mutes the amplifier without host action.
`ifndef SPK_REGS_VH
`define SPK_REGS_VH

// ****************************************************************
// pages and register offsets
// ****************************************************************
`define SPK_PG0 1'b0
`define SPK_PG1 1'b1
`define SPK_SWRST_ADDR 8'h01
`define SPK_OTP_ADDR 8'h2D
`define SPK_SHORT_ADDR 8'h2E
`define SPK_GPIO_ADDR 8'h34
`define SPK_ROUTE_ADDR 8'h3F
`define SPK_PWR_ADDR 8'h2D
`define SPK_GAIN_ADDR 8'h30

// ****************************************************************
// field positions
// ****************************************************************
`define SPK_FLAG_BIT 7
`define SPK_PWR_BIT 1
`define SPK_SWRST_BIT 0
`define SPK_GAIN_HI 6
`define SPK_GAIN_LO 4
`define SPK_MUTE_CODE 3'h0
`define SPK_GPIO_VAL_BIT 0
`define SPK_GPIO_IN_BIT 1
`define SPK_GPIO_MODE_LO 2
`define SPK_GPIO_MODE_HI 3
`define SPK_GPIO_OFF 2'h0
`define SPK_GPIO_INPUT 2'h1
`define SPK_GPIO_OUTPUT 2'h2
`define SPK_ROUTE_NONE 2'h0
`define SPK_ROUTE_A 2'h1
`define SPK_ROUTE_B 2'h2
`define SPK_ROUTE_MIX 2'h3
`define SPK_SWAP_BIT 2

// ****************************************************************
// reset values
// ****************************************************************
`define SPK_PWR_RST 1'b0
`define SPK_GAIN_RST 3'h0
`define SPK_ROUTE_RST 3'h3
`define SPK_GPIO_MODE_RST 2'h0
`define SPK_GPIO_VAL_RST 1'b0

`endif

/* logic/spk_sync.v */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// two-stage synchroniser for asynchronous pins
// ****************************************************************
module spk_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire nrst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

reg [W-1:0] meta_reg;

// first stage feeds only the second stage
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        meta_reg <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        meta_reg <= d;
        q <= meta_reg;
    end
end

endmodule

`default_nettype wire

/* logic/spk_fault_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "spk_regs.vh"

// ****************************************************************
// speaker driver control and fault handling
// ****************************************************************
module spk_fault_ctrl #(
    parameter SW = 16
) (
    input wire clk,
    input wire nrst,
    input wire reg_page,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire reg_rd_en,
    output reg [7:0] reg_rdata,
    input wire [SW-1:0] left_sample,
    input wire [SW-1:0] right_sample,
    input wire sample_valid,
    input wire short_det_pin,
    input wire overtemp_pin,
    input wire gpio_in,
    output reg gpio_out,
    output reg gpio_oe_n,
    output reg [SW+3:0] spk_level,
    output reg spk_stage_en,
    output reg spk_mute
);

// ****************************************************************
// pin synchronisation
// ****************************************************************
wire [2:0] pins_sync;
wire short_s;
wire otp_s;
wire gpio_s;

spk_sync #(.W(3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({gpio_in, overtemp_pin, short_det_pin}),
    .q(pins_sync)
);

assign short_s = pins_sync[0];
assign otp_s = pins_sync[1];
assign gpio_s = pins_sync[2];

// ****************************************************************
// register decode
// ****************************************************************
reg power_reg;
reg [2:0] gain_reg;
reg [2:0] route_reg;
reg [1:0] gpio_mode_reg;
reg gpio_val_reg;
reg short_latch_reg;

wire wr0;
wire wr1;
wire soft_rst;
wire pwr_wr;
wire stage_reset;

// page select for the two register pages
assign wr0 = reg_wr_en & (reg_page == `SPK_PG0);
assign wr1 = reg_wr_en & (reg_page == `SPK_PG1);

// software master reset, self clearing, acts in the write cycle
assign soft_rst = wr0 & (reg_addr == `SPK_SWRST_ADDR)
    & reg_wdata[`SPK_SWRST_BIT];

// a write of one to the power bit also restarts the power stage
assign pwr_wr = wr1 & (reg_addr == `SPK_PWR_ADDR);
assign stage_reset = pwr_wr & reg_wdata[`SPK_PWR_BIT];

// ****************************************************************
// writable control registers
// ****************************************************************
// power bit, gain field, routing and pin control
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        power_reg <= `SPK_PWR_RST;
        gain_reg <= `SPK_GAIN_RST;
        route_reg <= `SPK_ROUTE_RST;
        gpio_mode_reg <= `SPK_GPIO_MODE_RST;
        gpio_val_reg <= `SPK_GPIO_VAL_RST;
    end else if (soft_rst) begin
        power_reg <= `SPK_PWR_RST;
        gain_reg <= `SPK_GAIN_RST;
        route_reg <= `SPK_ROUTE_RST;
        gpio_mode_reg <= `SPK_GPIO_MODE_RST;
        gpio_val_reg <= `SPK_GPIO_VAL_RST;
    end else begin
        if (pwr_wr) begin
            power_reg <= reg_wdata[`SPK_PWR_BIT];
        end
        if (wr1 && reg_addr == `SPK_GAIN_ADDR) begin
            gain_reg <= reg_wdata[`SPK_GAIN_HI:`SPK_GAIN_LO];
        end
        if (wr0 && reg_addr == `SPK_ROUTE_ADDR) begin
            route_reg <= reg_wdata[2:0];
        end
        if (wr0 && reg_addr == `SPK_GPIO_ADDR) begin
            gpio_mode_reg <= reg_wdata[`SPK_GPIO_MODE_HI:`SPK_GPIO_MODE_LO];
            gpio_val_reg <= reg_wdata[`SPK_GPIO_VAL_BIT];
        end
    end
end

// ****************************************************************
// short-circuit latch
// ****************************************************************
// no write path reaches it: only the fault, the stage reset and
// the master reset move it; a fault beats a stage reset, the master reset beats both
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        short_latch_reg <= 1'b0;
    end else if (soft_rst) begin
        short_latch_reg <= 1'b0;
    end else if (short_s && power_reg) begin
        short_latch_reg <= 1'b1;
    end else if (stage_reset) begin
        short_latch_reg <= 1'b0;
    end
end

// ****************************************************************
// output stage enable and mute
// ****************************************************************
reg mute_now;
reg stage_now;

// stage off on latched short or while hot; overheating clears alone
always @* begin
    stage_now = power_reg & ~short_latch_reg & ~otp_s;
    mute_now = (gain_reg == `SPK_MUTE_CODE)
        | short_latch_reg | otp_s;
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        spk_stage_en <= 1'b0;
        spk_mute <= 1'b1;
    end else begin
        spk_stage_en <= stage_now;
        spk_mute <= mute_now;
    end
end

// ****************************************************************
// channel mixer and gain
// ****************************************************************
reg signed [SW-1:0] chan_a;
reg signed [SW-1:0] chan_b;
reg signed [SW:0] mix_sum;
reg signed [SW-1:0] mixed;
reg signed [SW+3:0] scaled;

// swap, select and average, then scale by the gain code
always @* begin
    chan_a = route_reg[`SPK_SWAP_BIT] ? right_sample : left_sample;
    chan_b = route_reg[`SPK_SWAP_BIT] ? left_sample : right_sample;
    mix_sum = {chan_a[SW-1], chan_a} + {chan_b[SW-1], chan_b};
    case (route_reg[1:0])
        `SPK_ROUTE_NONE: mixed = {SW{1'b0}};
        `SPK_ROUTE_A: mixed = chan_a;
        `SPK_ROUTE_B: mixed = chan_b;
        `SPK_ROUTE_MIX: mixed = mix_sum[SW:1];
        default: mixed = {SW{1'b0}};
    endcase
    scaled = mixed * $signed({1'b0, gain_reg});
end

// hold the last level; zero whenever muted or the stage is off
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        spk_level <= {(SW+4){1'b0}};
    end else if (mute_now || !stage_now) begin
        spk_level <= {(SW+4){1'b0}};
    end else if (sample_valid) begin
        spk_level <= scaled;
    end
end

// ****************************************************************
// general-purpose pin
// ****************************************************************
// drives only in output mode; enable is active low
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        gpio_out <= 1'b0;
        gpio_oe_n <= 1'b1;
    end else begin
        gpio_out <= gpio_val_reg;
        gpio_oe_n <= (gpio_mode_reg != `SPK_GPIO_OUTPUT);
    end
end

// ****************************************************************
// register readback
// ****************************************************************
reg [7:0] rd_mux;

// fault flags are read-only views of hardware state
always @* begin
    rd_mux = 8'h00;
    if (reg_page == `SPK_PG0) begin
        case (reg_addr)
            `SPK_OTP_ADDR: rd_mux[`SPK_FLAG_BIT] = otp_s;
            `SPK_SHORT_ADDR: rd_mux[`SPK_FLAG_BIT] = short_latch_reg;
            `SPK_ROUTE_ADDR: rd_mux[2:0] = route_reg;
            `SPK_GPIO_ADDR: begin
                rd_mux[`SPK_GPIO_MODE_HI:`SPK_GPIO_MODE_LO] = gpio_mode_reg;
                rd_mux[`SPK_GPIO_VAL_BIT] = gpio_val_reg;
                rd_mux[`SPK_GPIO_IN_BIT] =
                    (gpio_mode_reg == `SPK_GPIO_INPUT) & gpio_s;
            end
            default: rd_mux = 8'h00;
        endcase
    end else begin
        case (reg_addr)
            `SPK_PWR_ADDR: rd_mux[`SPK_PWR_BIT] = power_reg;
            `SPK_GAIN_ADDR: rd_mux[`SPK_GAIN_HI:`SPK_GAIN_LO] = gain_reg;
            default: rd_mux = 8'h00;
        endcase
    end
end

// read data is registered one cycle after the strobe
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
        reg_rdata <= rd_mux;
    end
end

endmodule

`default_nettype wire

/* verif/spk_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// general pin wire: comparator and pull-up share it with the block
// ****************************************************************
module spk_pin_model (
    input wire logic gpio_out,
    input wire logic gpio_oe_n,
    input wire logic comp_fault,
    output logic gpio_in
);
    // block drives when enabled, else comparator sinks or pull-up wins
    assign gpio_in = !gpio_oe_n ? gpio_out : !comp_fault;
endmodule

`default_nettype wire

/* verif/spk_fault_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// port checker
// ****************************************************************
module spk_fault_ctrl_chk #(
    parameter SW = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic short_det_pin,
    input wire logic overtemp_pin,
    input wire logic gpio_out,
    input wire logic gpio_oe_n,
    input wire logic [SW+3:0] spk_level,
    input wire logic spk_stage_en,
    input wire logic spk_mute
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // page-qualified write strobes
    wire wr0 = reg_wr_en && !reg_page;
    wire wr1 = reg_wr_en && reg_page;
    a_quiet_level: assert property (
        (spk_mute || !spk_stage_en) [*2] |-> spk_level == 0)
        else $error("speaker level not zero while silent");
    a_hot_stage_off: assert property (
        overtemp_pin [*4] |-> !spk_stage_en && spk_mute)
        else $error("stage still switching while hot");
    a_short_stage_off: assert property (
        short_det_pin [*5] |-> !spk_stage_en)
        else $error("stage still on during overcurrent");
    a_power_readback: assert property (
        wr1 && reg_addr == 8'h2D ##2 reg_rd_en && reg_page
        && reg_addr == 8'h2D |=> reg_rdata == ($past(reg_wdata, 3) & 8'h02))
        else $error("power register readback wrong");
    a_power_off: assert property (
        wr1 && reg_addr == 8'h2D && !reg_wdata[1] |-> ##2 !spk_stage_en)
        else $error("stage on with power bit clear");
    a_pin_drive: assert property (
        wr0 && reg_addr == 8'h34 && reg_wdata[3:0] == 4'h9
        |-> ##2 !gpio_oe_n && gpio_out)
        else $error("pin not driven high in output mode");
    a_pin_listen: assert property (
        wr0 && reg_addr == 8'h34 && reg_wdata[3:2] == 2'h1 |-> ##2 gpio_oe_n)
        else $error("pin driven in input mode");
    a_soft_reset: assert property (
        wr0 && reg_addr == 8'h01 && reg_wdata[0]
        |-> ##2 spk_mute && !spk_stage_en)
        else $error("soft reset left stage running");
endmodule

bind spk_fault_ctrl spk_fault_ctrl_chk #(.SW(SW)) spk_fault_ctrl_chk_inst (
    .clk(clk), .nrst(nrst), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .short_det_pin(short_det_pin),
    .overtemp_pin(overtemp_pin), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .spk_level(spk_level), .spk_stage_en(spk_stage_en), .spk_mute(spk_mute));

`default_nettype wire

/* verif/spk_fault_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

// ****************************************************************
// testbench
// ****************************************************************
module spk_fault_ctrl_tb;
    localparam int SW = 16;
    logic clk = 0, nrst = 0, pg = 0, wr = 0, rd = 0, sv = 0, was_rd;
    logic sh = 0, ot = 0, cf = 0, gin, gout, goe_n, st, mu;
    logic [7:0] ad = 0, wd = 0, rdat;
    logic [SW-1:0] ls = 0, rs = 0;
    logic [SW+3:0] lvl;
    logic [SW+3:0] exp_q[$];
    logic [SW+3:0] exp_v;
    int n_errors = 0, cmp_count = 0;
    integer seed = 32'hf371;
    always #2.5 clk = ~clk;
    spk_fault_ctrl #(.SW(SW)) spk_fault_ctrl_inst (.clk(clk), .nrst(nrst),
        .reg_page(pg), .reg_addr(ad), .reg_wr_en(wr), .reg_wdata(wd),
        .reg_rd_en(rd), .reg_rdata(rdat), .left_sample(ls),
        .right_sample(rs), .sample_valid(sv), .short_det_pin(sh),
        .overtemp_pin(ot), .gpio_in(gin), .gpio_out(gout),
        .gpio_oe_n(goe_n), .spk_level(lvl), .spk_stage_en(st),
        .spk_mute(mu));
    spk_pin_model spk_pin_model_inst (.gpio_out(gout), .gpio_oe_n(goe_n),
        .comp_fault(cf), .gpio_in(gin));
    // inputs move one ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic p, input logic [7:0] a, d);
        pg = p; ad = a; wd = d; wr = 1; tick(1); wr = 0; tick(1);
    endtask
    task automatic rreg(input logic p, input logic [7:0] a, d);
        pg = p; ad = a; rd = 1; exp_q.push_back((SW+4)'(d));
        tick(1); rd = 0; tick(1);
    endtask
    // one sample pair, expected level from route and gain codes
    task automatic play(input int route, gain);
        logic signed [SW+3:0] a, b, m;
        ls = SW'($random(seed)); rs = SW'($random(seed));
        a = $signed(route[2] ? rs : ls);
        b = $signed(route[2] ? ls : rs);
        m = route[1:0] == 0 ? 0 : route[1:0] == 1 ? a :
            route[1:0] == 2 ? b : (a + b) >>> 1;
        exp_q.push_back((SW+4)'(m * gain));
        sv = 1; tick(1); sv = 0; tick(1);
    endtask
    task automatic defaults;
        rreg(1, 8'h2D, 8'h00);
        rreg(1, 8'h30, 8'h00);
        rreg(0, 8'h3F, 8'h03);
        rreg(0, 8'h34, 8'h00);
        rreg(0, 8'h2E, 8'h00);
        rreg(0, 8'hFF, 8'h00);
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // result watcher: oldest note against read data or speaker level
    always @(posedge clk) if (rd === 1'b1 || sv === 1'b1) begin
        was_rd = rd;
        #2;
        // pop once: the compare macro names its expected value twice
        exp_v = exp_q.pop_front();
        `CHK("result", exp_v, was_rd ? (SW+4)'(rdat) : lvl)
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude;
    end
    initial begin
        tick(16); nrst = 1; tick(1);
        defaults;
        wreg(1, 8'h2D, 8'h00); wreg(1, 8'h2D, 8'h02);
        rreg(1, 8'h2D, 8'h02);
        for (int i = 0; i < 8; i++) begin
            wreg(0, 8'h3F, 8'(i)); wreg(1, 8'h30, 8'((7 - i) << 4));
            play(i, 7 - i);
        end
        // unmute first so that a fault-driven mute is visible
        wreg(1, 8'h30, 8'h30);
        ot = 1; tick(6);
        rreg(0, 8'h2D, 8'h80);
        `CHK("stage", 1'b0, st)
        `CHK("mute", 1'b1, mu)
        wreg(0, 8'h2D, 8'h00); rreg(0, 8'h2D, 8'h80);
        ot = 0; tick(6);
        `CHK("stage", 1'b1, st)
        `CHK("mute", 1'b0, mu)
        sh = 1; tick(6);
        rreg(0, 8'h2E, 8'h80);
        `CHK("mute", 1'b1, mu)
        `CHK("stage", 1'b0, st)
        // a sample during the shutdown must come out as silence
        play(7, 0);
        // two stage resets: the first while the short remains, the second after it clears
        wreg(1, 8'h2D, 8'h02); tick(4);
        rreg(0, 8'h2E, 8'h80);
        sh = 0; tick(4); wreg(1, 8'h2D, 8'h02); tick(4);
        rreg(0, 8'h2E, 8'h00);
        `CHK("stage", 1'b1, st)
        rreg(0, 8'h3F, 8'h07);
        play(7, 3);
        wreg(0, 8'h34, 8'h04); cf = 1; tick(4);
        rreg(0, 8'h34, 8'h04);
        cf = 0; tick(4);
        rreg(0, 8'h34, 8'h06);
        // open-load test: mute before the pin drives the circuit
        wreg(1, 8'h30, 8'h00);
        `CHK("mute", 1'b1, mu)
        wreg(0, 8'h34, 8'h09);
        `CHK("pin", 2'b01, {goe_n, gout})
        wreg(0, 8'h34, 8'h08);
        `CHK("pin", 2'b00, {goe_n, gout})
        // inverted circuit: pin high in normal run, low only for the test
        wreg(0, 8'h34, 8'h09);
        `CHK("pin", 2'b01, {goe_n, gout})
        wreg(0, 8'h34, 8'h08);
        `CHK("pin", 2'b00, {goe_n, gout})
        wreg(0, 8'h34, 8'h09);
        wreg(1, 8'h30, 8'h50);
        `CHK("mute", 1'b0, mu)
        // hardware reset in mid-run
        nrst = 0; tick(2);
        `CHK("mute", 1'b1, mu)
        `CHK("stage", 1'b0, st)
        nrst = 1; tick(1);
        defaults;
        wreg(1, 8'h2D, 8'h02); wreg(1, 8'h30, 8'h50); wreg(0, 8'h01, 8'h01);
        defaults;
        conclude;
    end
endmodule

`default_nettype wire
